// File: design/fvc_pkg.sv
// constants for the volatile configuration register two block
// assumes opcodes arrive already assembled into whole bytes
package fvc_pkg;

  // ******************************
  // command opcodes
  // ******************************
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_WREN_NV = 8'h06;
  localparam logic [7:0] OP_READ_TWO = 8'h15;
  localparam logic [7:0] OP_READ_THREE = 8'h33;
  localparam logic [7:0] OP_ENTER_WIDE = 8'h38;
  localparam logic [7:0] OP_WREN_VOL = 8'h50;
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_BURST_LEN = 8'h77;
  localparam logic [7:0] OP_ENTER_LONG = 8'hB7;
  localparam logic [7:0] OP_EXIT_LONG = 8'hE9;
  localparam logic [7:0] OP_EXIT_WIDE = 8'hF5;

  // ******************************
  // register addresses for any-register access
  // ******************************
  localparam logic [23:0] ADDR_CFG_TWO_V = 24'h000003;
  localparam logic [23:0] ADDR_CFG_THREE_V = 24'h000004;

  // ******************************
  // field positions
  // ******************************
  localparam int B_PIN_RST = 7;
  localparam int B_DRV_HI = 6;
  localparam int B_DRV_LO = 5;
  localparam int B_WIDE = 3;
  localparam int B_PROT = 2;
  localparam int B_PWRUP_LEN = 1;
  localparam int B_CUR_LEN = 0;
  localparam int B_WRAP_DIS = 4;
  localparam int B_WRAP_HI = 6;
  localparam int B_WRAP_LO = 5;
  localparam int B_LAT_HI = 3;

  // ******************************
  // masks, reset values and byte counts
  // ******************************
  localparam logic [7:0] MASK_TWO_WR = 8'hED;
  localparam logic [7:0] MASK_THREE_WR = 8'h7F;
  localparam logic [7:0] RST_TWO = 8'h60;
  localparam logic [7:0] RST_THREE = 8'h70;
  localparam logic [2:0] REGS_N_TWO = 3'h3;
  localparam logic [2:0] REGS_N_THREE = 3'h4;

  // typical pull-down impedance per drive code, in ohms
  function automatic logic [6:0] fvc_ohms(input logic [1:0] code);
    unique case (code)
      2'h0: fvc_ohms = 7'h12;
      2'h1: fvc_ohms = 7'h1A;
      2'h2: fvc_ohms = 7'h2F;
      2'h3: fvc_ohms = 7'h47;
    endcase
  endfunction

endpackage

// File: design/fvc_dec_if.sv
// decoded command strobes between the decoder and the register logic
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fvc_dec_if;
  logic wr_two;
  logic wr_three;
  logic [7:0] two_data;
  logic [7:0] three_data;
  logic rd_two;
  logic rd_three;
  logic rd_none;
  logic enter_wide;
  logic exit_wide;
  logic enter_long;
  logic exit_long;
  logic wen_vol;
  logic wen_nv;
  logic is_write;
  modport dec (output wr_two, wr_three, two_data, three_data, rd_two,
    rd_three, rd_none, enter_wide, exit_wide, enter_long, exit_long,
    wen_vol, wen_nv, is_write);
  modport cfg (input wr_two, wr_three, two_data, three_data, rd_two,
    rd_three, rd_none, enter_wide, exit_wide, enter_long, exit_long,
    wen_vol, wen_nv, is_write);
endinterface
`default_nettype wire

// File: design/fvc_pin_sync.sv
// three-stage synchroniser for pad inputs
// assumes pads are asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module fvc_pin_sync
  import fvc_pkg::*;
#(
  parameter int W = 2,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } fvc_sync_t;

  fvc_sync_t st;
  fvc_sync_t next_st;
  logic [W-1:0] agree;

  // a change counts only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.lvl[i];
  end

  // shift; first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = agree;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= {IDLE, IDLE, IDLE, IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.lvl;

endmodule
`default_nettype wire

// File: design/fvc_cmd_decode.sv
// opcode decoder: turns one taken command into strobes
// assumes a command is presented whole for one cycle
`timescale 1ns/1ps
`default_nettype none
module fvc_cmd_decode
  import fvc_pkg::*;
(
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic [2:0] cmd_nbytes_i,
  fvc_dec_if.dec dec
);

  logic any_two;
  logic any_three;
  logic op_regs;
  logic op_wany;
  logic op_rany;

  // ******************************
  // address match and opcode groups
  // ******************************
  assign any_two = (cmd_addr_i == ADDR_CFG_TWO_V);
  assign any_three = (cmd_addr_i == ADDR_CFG_THREE_V);
  assign op_regs = cmd_valid_i && (cmd_opcode_i == OP_WRITE_REGS);
  assign op_wany = cmd_valid_i && (cmd_opcode_i == OP_WRITE_ANY);
  assign op_rany = cmd_valid_i && (cmd_opcode_i == OP_READ_ANY);

  // write-registers carries status, cfg one, two, three in byte order
  always_comb begin
    dec.wr_two = (op_regs && cmd_nbytes_i >= REGS_N_TWO) ||
      (op_wany && any_two);
    dec.wr_three = (op_regs && cmd_nbytes_i >= REGS_N_THREE) ||
      (op_wany && any_three);
    dec.two_data = op_regs ? cmd_wdata_i[23:16] : cmd_wdata_i[7:0];
    dec.three_data = op_regs ? cmd_wdata_i[31:24] : cmd_wdata_i[7:0];
    dec.rd_two = (cmd_valid_i && cmd_opcode_i == OP_READ_TWO) ||
      (op_rany && any_two);
    dec.rd_three = (cmd_valid_i && cmd_opcode_i == OP_READ_THREE) ||
      (op_rany && any_three);
    dec.rd_none = op_rany && !any_two && !any_three;
    dec.enter_wide = cmd_valid_i && (cmd_opcode_i == OP_ENTER_WIDE);
    dec.exit_wide = cmd_valid_i && (cmd_opcode_i == OP_EXIT_WIDE);
    dec.enter_long = cmd_valid_i && (cmd_opcode_i == OP_ENTER_LONG);
    dec.exit_long = cmd_valid_i && (cmd_opcode_i == OP_EXIT_LONG);
    dec.wen_vol = cmd_valid_i && (cmd_opcode_i == OP_WREN_VOL);
    dec.wen_nv = cmd_valid_i && (cmd_opcode_i == OP_WREN_NV);
    dec.is_write = op_regs || op_wany ||
      (cmd_valid_i && cmd_opcode_i == OP_BURST_LEN);
  end

endmodule
`default_nettype wire

// File: design/fvc_cfg_top.sv
// volatile configuration register two, register three copy,
// and the pin and protocol mode logic they steer
// assumes commands are decoded by an spi front end on clock_i,
// and the nonvolatile copies are presented steady on their ports
// all outputs are registered; derived mode outputs trail the
// register bits they come from by one clock
`timescale 1ns/1ps
`default_nettype none
module fvc_cfg_top
  import fvc_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic [2:0] cmd_nbytes_i,
  input wire logic [7:0] nv_config_two_i,
  input wire logic [7:0] nv_config_three_i,
  input wire logic nv_pwrup_len_upd_i,
  input wire logic nv_pwrup_len_i,
  input wire logic sw_reset_i,
  input wire logic quad_enable_i,
  input wire logic array_read_i,
  input wire logic cs_n_pin_i,
  input wire logic io3_pin_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic hw_reset_o,
  output logic pin_reset_enable_o,
  output logic pin_reset_armed_o,
  output logic [1:0] drive_strength_select_o,
  output logic [6:0] drive_ohms_o,
  output logic four_wide_protocol_o,
  output logic quad_active_o,
  output logic single_read_ok_o,
  output logic dual_read_ok_o,
  output logic quad_read_ok_o,
  output logic io2_is_data_o,
  output logic protection_select_o,
  output logic powerup_addr_len_o,
  output logic current_addr_len_o,
  output logic wrap_active_o,
  output logic [1:0] wrap_len_o,
  output logic [3:0] read_latency_o
);

  // ******************************
  // state
  // ******************************
  // every flop of this module except the pad synchroniser lives in this one struct
  typedef struct packed {
    logic loaded;
    logic wel_vol;
    // volatile register images
    logic [7:0] cfg_two;
    logic [7:0] cfg_three;
    // read answer
    logic rd_valid;
    logic [7:0] rd_data;
    // pin reset and mode outputs
    logic hw_reset;
    logic armed;
    logic quad_active;
    logic single_ok;
    logic dual_ok;
    logic quad_ok;
    logic io2_data;
    logic wrap_active;
    logic [6:0] ohms;
  } fvc_state_t;

  fvc_state_t st;
  fvc_state_t next_st;
  // filtered pads: [1] chip select, [0] io3
  logic [1:0] pins;
  logic cs_high;
  logic io3_low;
  logic reload;
  logic wide;
  // what a register write would leave in register two
  logic [7:0] two_w;

  // decoded strobes shared with the opcode decoder
  fvc_dec_if dec_bus ();

  // purely combinational; a command acts at the next edge
  fvc_cmd_decode u_dec (
    .cmd_valid_i(cmd_valid_i),
    .cmd_opcode_i(cmd_opcode_i),
    .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i),
    .cmd_nbytes_i(cmd_nbytes_i),
    .dec(dec_bus.dec)
  );

  // pads idle high: cs deselected, io3 released
  // limitation: pad pulses not sampled at two consecutive edges are lost
  fvc_pin_sync #(
    .W(2),
    .IDLE(2'h3)
  ) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i({cs_n_pin_i, io3_pin_i}),
    .level_o(pins)
  );

  // io3 low asks for reset; cs high means the bus is idle
  assign cs_high = pins[1];
  assign io3_low = !pins[0];
  assign wide = st.cfg_two[B_WIDE];

  // ******************************
  // reload and mode logic
  // ******************************

  // hazard: a non-read command in a reload cycle is dropped on purpose
  // the first cycle after release, a software reset and a pin reset
  // all reload; the pin reset is level, so it keeps reloading while held
  always_comb begin
    reload = !st.loaded || sw_reset_i || st.hw_reset;
  end

  // writable-bit merge for volatile register two; bit 1 is kept and
  // the reserved bit forced low
  always_comb begin
    two_w = (st.cfg_two & ~MASK_TWO_WR) |
      (dec_bus.two_data & MASK_TWO_WR);
    two_w[B_WRAP_DIS] = 1'b0;
  end

  always_comb begin
    next_st = st;
    // loaded is low only in the first clock after release
    next_st.loaded = 1'b1;
    // the read strobe is a one-clock pulse
    next_st.rd_valid = 1'b0;

    // ******************************
    // register updates
    // ******************************
    // reload wins over every command except a read in the same clock
    if (reload) begin
      next_st.cfg_two = nv_config_two_i;
      next_st.cfg_two[B_WRAP_DIS] = 1'b0;
      // current length starts from the power-up length
      next_st.cfg_two[B_CUR_LEN] = nv_config_two_i[B_PWRUP_LEN];
      // bit 7 of register three is reserved and stays low
      next_st.cfg_three = nv_config_three_i & MASK_THREE_WR;
      // a reload never keeps a pending volatile enable
      next_st.wel_vol = 1'b0;
    end else begin
      // volatile writes need the volatile write enable first
      if (dec_bus.wr_two && st.wel_vol) begin
        next_st.cfg_two = two_w;
      end
      // register three takes byte four of 01h, or byte one of 71h
      if (dec_bus.wr_three && st.wel_vol) begin
        next_st.cfg_three = dec_bus.three_data & MASK_THREE_WR;
      end
      // set burst length needs no volatile enable
      if (cmd_valid_i && cmd_opcode_i == OP_BURST_LEN) begin
        next_st.cfg_three = cmd_wdata_i[7:0] & MASK_THREE_WR;
      end
      // only the wide bit moves; quad enable lives elsewhere
      if (dec_bus.enter_wide) begin
        next_st.cfg_two[B_WIDE] = 1'b1;
      end
      if (dec_bus.exit_wide) begin
        next_st.cfg_two[B_WIDE] = 1'b0;
      end
      // address length commands need no enable either
      if (dec_bus.enter_long) begin
        next_st.cfg_two[B_CUR_LEN] = 1'b1;
      end
      if (dec_bus.exit_long) begin
        next_st.cfg_two[B_CUR_LEN] = 1'b0;
      end
      // nonvolatile update drags both length bits; last word wins
      if (nv_pwrup_len_upd_i) begin
        next_st.cfg_two[B_PWRUP_LEN] = nv_pwrup_len_i;
        next_st.cfg_two[B_CUR_LEN] = nv_pwrup_len_i;
      end
      // write enable is consumed by the next 01h, 71h or 77h write, or by 06h
      if (dec_bus.wen_vol) begin
        next_st.wel_vol = 1'b1;
      end else if (dec_bus.wen_nv || dec_bus.is_write) begin
        next_st.wel_vol = 1'b0;
      end
    end

    // ******************************
    // read answers
    // ******************************
    // answers show the value before a write in the same cycle
    if (dec_bus.rd_two) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data = st.cfg_two;
    end else if (dec_bus.rd_three) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data = st.cfg_three;
    end else if (dec_bus.rd_none) begin
      next_st.rd_valid = 1'b1;
      // an unmapped register address answers zero
      next_st.rd_data = 8'h00;
    end

    // ******************************
    // pin and protocol modes
    // ******************************
    // io3 is a reset input unless cs is low while quad enable and the wide bit are both set
    next_st.armed = st.cfg_two[B_PIN_RST] &&
      (cs_high || !quad_enable_i || !wide);
    // with the enable clear the pad level is ignored
    next_st.hw_reset = st.armed && io3_low &&
      st.cfg_two[B_PIN_RST];
    // wide protocol forces quad on and drops single and dual
    next_st.quad_active = wide || quad_enable_i;
    next_st.single_ok = !wide;
    next_st.dual_ok = !wide;
    next_st.quad_ok = wide || quad_enable_i;
    next_st.io2_data = wide || quad_enable_i;
    // registers and security regions never wrap
    next_st.wrap_active = array_read_i &&
      !st.cfg_three[B_WRAP_DIS];
    // ohms trail the drive code by one clock
    next_st.ohms = fvc_ohms(st.cfg_two[B_DRV_HI:B_DRV_LO]);
  end

  // ******************************
  // registers
  // ******************************
  // reset values are constants; nonvolatile data lands one cycle later
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.cfg_two <= RST_TWO;
      st.cfg_three <= RST_THREE;
      st.single_ok <= 1'b1;
      st.dual_ok <= 1'b1;
      // drive reset follows the pre-load code of register two
      st.ohms <= fvc_ohms(RST_TWO[B_DRV_HI:B_DRV_LO]);
    end else begin
      // every flop updates on every edge; there is no enable
      st <= next_st;
    end
  end

  // ******************************
  // outputs, all straight from state bits
  // ******************************
  // read port
  assign rd_valid_o = st.rd_valid;
  assign rd_data_o = st.rd_data;
  // pin reset
  assign hw_reset_o = st.hw_reset;
  assign pin_reset_enable_o = st.cfg_two[B_PIN_RST];
  assign pin_reset_armed_o = st.armed;
  // drive strength
  assign drive_strength_select_o = st.cfg_two[B_DRV_HI:B_DRV_LO];
  assign drive_ohms_o = st.ohms;
  // protocol and read modes
  assign four_wide_protocol_o = st.cfg_two[B_WIDE];
  assign quad_active_o = st.quad_active;
  assign single_read_ok_o = st.single_ok;
  assign dual_read_ok_o = st.dual_ok;
  assign quad_read_ok_o = st.quad_ok;
  assign io2_is_data_o = st.io2_data;
  // protection and address length
  assign protection_select_o = st.cfg_two[B_PROT];
  assign powerup_addr_len_o = st.cfg_two[B_PWRUP_LEN];
  assign current_addr_len_o = st.cfg_two[B_CUR_LEN];
  // register three fields
  assign wrap_active_o = st.wrap_active;
  assign wrap_len_o = st.cfg_three[B_WRAP_HI:B_WRAP_LO];
  assign read_latency_o = st.cfg_three[B_LAT_HI:0];

endmodule
`default_nettype wire

// File: test/fvc_cfg_asserts.sv
// port-level checker for the configuration register two block
// assumes it is bound to fvc_cfg_top with one clock domain
`timescale 1ns/1ps
`default_nettype none
module fvc_cfg_asserts
  import fvc_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_opcode_i,
  input wire logic nv_pwrup_len_upd_i,
  input wire logic nv_pwrup_len_i,
  input wire logic sw_reset_i,
  input wire logic quad_enable_i,
  input wire logic rd_valid_o,
  input wire logic [7:0] rd_data_o,
  input wire logic hw_reset_o,
  input wire logic pin_reset_enable_o,
  input wire logic pin_reset_armed_o,
  input wire logic [1:0] drive_strength_select_o,
  input wire logic [6:0] drive_ohms_o,
  input wire logic four_wide_protocol_o,
  input wire logic quad_active_o,
  input wire logic single_read_ok_o,
  input wire logic dual_read_ok_o,
  input wire logic quad_read_ok_o,
  input wire logic io2_is_data_o,
  input wire logic protection_select_o,
  input wire logic powerup_addr_len_o,
  input wire logic current_addr_len_o
);
  // ****************
  // helper logic
  // ****************
  logic is_read;
  logic quiet;
  logic [7:0] cfg_two;
  logic [6:0] ohms_exp;
  // software or pin reset cycles and nonvolatile length updates override commands, so those cycles are left out
  assign quiet = !sw_reset_i && !hw_reset_o && !nv_pwrup_len_upd_i;
  assign is_read = cmd_valid_i && (cmd_opcode_i == OP_READ_TWO ||
    cmd_opcode_i == OP_READ_THREE || cmd_opcode_i == OP_READ_ANY);
  assign cfg_two = {pin_reset_enable_o, drive_strength_select_o, 1'b0,
    four_wide_protocol_o, protection_select_o, powerup_addr_len_o,
    current_addr_len_o};
  // typical ohms per drive code, kept apart from the design table
  always_comb begin
    case (drive_strength_select_o)
      2'h0: ohms_exp = 7'h12;
      2'h1: ohms_exp = 7'h1A;
      2'h2: ohms_exp = 7'h2F;
      default: ohms_exp = 7'h47;
    endcase
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // ****************
  // assertions
  // ****************
  a_read_answer:
  assert property (is_read |=> rd_valid_o) else $error("read unanswered");
  a_read_two_data:
  assert property (cmd_valid_i && cmd_opcode_i == OP_READ_TWO |=>
    rd_data_o == $past(cfg_two)) else $error("bad register two data");
  a_wide_quad:
  assert property (four_wide_protocol_o |=> quad_active_o &&
    quad_read_ok_o && io2_is_data_o && !single_read_ok_o &&
    !dual_read_ok_o)
    else $error("wide mode not quad");
  a_legacy_modes:
  assert property (!four_wide_protocol_o |=> single_read_ok_o &&
    dual_read_ok_o && quad_read_ok_o == $past(quad_enable_i) &&
    io2_is_data_o == $past(quad_enable_i)) else $error("legacy mode");
  a_wide_cmds:
  assert property (cmd_valid_i && quiet && (cmd_opcode_i == OP_ENTER_WIDE
    || cmd_opcode_i == OP_EXIT_WIDE) |=> four_wide_protocol_o ==
    ($past(cmd_opcode_i) == OP_ENTER_WIDE)) else $error("wide command");
  a_long_cmds:
  assert property (cmd_valid_i && quiet && (cmd_opcode_i == OP_ENTER_LONG
    || cmd_opcode_i == OP_EXIT_LONG) |=> current_addr_len_o ==
    ($past(cmd_opcode_i) == OP_ENTER_LONG)) else $error("long command");
  a_pwrup_follow:
  assert property (nv_pwrup_len_upd_i && !sw_reset_i && !hw_reset_o |=>
    powerup_addr_len_o == $past(nv_pwrup_len_i) &&
    current_addr_len_o == $past(nv_pwrup_len_i)) else $error("length");
  a_arm_legacy:
  assert property (pin_reset_enable_o && !four_wide_protocol_o |=>
    pin_reset_armed_o) else $error("pin reset not armed");
  a_pin_gate:
  assert property (hw_reset_o |-> $past(pin_reset_armed_o))
    else $error("pin reset while unarmed");
  a_drive_ohms:
  assert property (1'b1 |=> drive_ohms_o == $past(ohms_exp))
    else $error("drive ohms");
endmodule
bind fvc_cfg_top fvc_cfg_asserts i_chk (.*);
`default_nettype wire

// File: test/fvc_host_model.sv
// host model that issues register commands to the block
// assumes each task is entered just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module fvc_host_model
  import fvc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output var logic cmd_valid_o,
  output var logic [7:0] cmd_opcode_o,
  output var logic [23:0] cmd_addr_o,
  output var logic [31:0] cmd_wdata_o,
  output var logic [2:0] cmd_nbytes_o
);
  // ****************
  // command tasks
  // ****************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_opcode_o = 8'h00;
    cmd_addr_o = 24'h000000;
    cmd_wdata_o = 32'h00000000;
    cmd_nbytes_o = 3'h0;
  end
  // back-to-back calls give commands on consecutive edges
  task automatic send(input logic [7:0] op, input logic [23:0] adr,
      input logic [31:0] dat, input logic [2:0] nb);
    cmd_valid_o <= 1'b1;
    cmd_opcode_o <= op;
    cmd_addr_o <= adr;
    cmd_wdata_o <= dat;
    cmd_nbytes_o <= nb;
    @(posedge clock_i);
  endtask
  // released lines flip so a stale command never looks intact
  task automatic idle();
    cmd_valid_o <= 1'b0;
    cmd_opcode_o <= ~cmd_opcode_o;
    cmd_addr_o <= ~cmd_addr_o;
    cmd_wdata_o <= ~cmd_wdata_o;
    @(posedge clock_i);
  endtask
  // the answer stands one cycle, so it is taken at that edge
  task automatic rd(input logic [7:0] op, input logic [23:0] adr,
      output logic [7:0] dat, output logic got);
    send(op, adr, 32'h00000000, 3'h0);
    idle();
    got = rd_valid_i;
    dat = rd_data_i;
  endtask
  // register writes always follow the volatile write enable
  task automatic wr(input logic [7:0] op, input logic [23:0] adr,
      input logic [31:0] dat, input logic [2:0] nb);
    send(OP_WREN_VOL, 24'h000000, 32'h00000000, 3'h0);
    send(op, adr, dat, nb);
    idle();
  endtask
endmodule
`default_nettype wire

// File: test/test_flash_volatile_config_reg2.sv
// self-checking bench for the configuration register two block
// assumes the host model drives commands and the bench the rest
`timescale 1ns/1ps
`default_nettype none
module test_flash_volatile_config_reg2
  import fvc_pkg::*;
;
  logic clock_i, nrst_i, cmd_valid_i, nv_pwrup_len_upd_i, nv_pwrup_len_i;
  logic sw_reset_i, quad_enable_i, array_read_i, cs_n_pin_i, io3_pin_i;
  logic [7:0] cmd_opcode_i, nv_config_two_i, nv_config_three_i, rd_data_o;
  logic [23:0] cmd_addr_i;
  logic [31:0] cmd_wdata_i;
  logic [2:0] cmd_nbytes_i;
  logic rd_valid_o, hw_reset_o, pin_reset_enable_o, pin_reset_armed_o;
  logic four_wide_protocol_o, quad_active_o, single_read_ok_o;
  logic dual_read_ok_o, quad_read_ok_o, io2_is_data_o, protection_select_o;
  logic powerup_addr_len_o, current_addr_len_o, wrap_active_o;
  logic [1:0] drive_strength_select_o, wrap_len_o;
  logic [6:0] drive_ohms_o;
  logic [3:0] read_latency_o;
  int n_fail;
  int checks_done;
  logic [6:0] ohms_tab [4] = '{7'h12, 7'h1A, 7'h2F, 7'h47};
  // ****************
  // harness
  // ****************
  fvc_host_model i_host (
    .clock_i(clock_i),
    .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o),
    .cmd_valid_o(cmd_valid_i),
    .cmd_opcode_o(cmd_opcode_i),
    .cmd_addr_o(cmd_addr_i),
    .cmd_wdata_o(cmd_wdata_i),
    .cmd_nbytes_o(cmd_nbytes_i)
  );
  fvc_cfg_top i_dut (.*);
  // 20 MHz clock
  always #25 clock_i = ~clock_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic expect_rd(input string what, input logic [7:0] op,
      input logic [23:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    logic g;
    i_host.rd(op, adr, d, g);
    check(what, g, 8'h01);
    check(what, d, exp);
  endtask
  // ****************
  // scenarios
  // ****************
  // nv two 96h loads as 87h: bit4 dropped, bit0 copies bit1
  task automatic t_reload();
    expect_rd("two", OP_READ_TWO, 24'h0, 8'h87);
    expect_rd("three", OP_READ_THREE, 24'h0, 8'h75);
    expect_rd("any two", OP_READ_ANY, ADDR_CFG_TWO_V, 8'h87);
    expect_rd("any three", OP_READ_ANY, ADDR_CFG_THREE_V, 8'h75);
    expect_rd("unmapped", OP_READ_ANY, 24'h000005, 8'h00);
    check("wrap off", wrap_active_o, 8'h00);
    $display("t_reload done");
  endtask
  task automatic t_write();
    i_host.send(OP_WRITE_ANY, ADDR_CFG_TWO_V, 32'h0, 3'h0);
    i_host.idle();
    expect_rd("no enable", OP_READ_TWO, 24'h0, 8'h87);
    i_host.wr(OP_WRITE_ANY, ADDR_CFG_TWO_V, 32'h12, 3'h0);
    expect_rd("masked", OP_READ_TWO, 24'h0, 8'h02);
    i_host.wr(OP_WRITE_REGS, 24'h0, 32'h00E50000, 3'h3);
    expect_rd("wrr", OP_READ_TWO, 24'h0, 8'hE7);
    check("block lock", protection_select_o, 8'h01);
    for (int c = 0; c < 4; c++) begin
      i_host.wr(OP_WRITE_ANY, ADDR_CFG_TWO_V, {24'h0, 1'b1, c[1:0], 5'h0},
        3'h0);
      tick(1);
      check("ohms", drive_ohms_o, {1'b0, ohms_tab[c]});
    end
    check("legacy lock", protection_select_o, 8'h00);
    $display("t_write done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      quad_enable_i <= m[0];
      cs_n_pin_i <= !(m[1] & m[0]);
      i_host.send(m[1] ? OP_ENTER_WIDE : OP_EXIT_WIDE, 24'h0, 32'h0, 3'h0);
      i_host.idle();
      tick(4);
      check("wide", four_wide_protocol_o, m[1]);
      check("quad rd", quad_read_ok_o, m[1] | m[0]);
      check("io2 data", io2_is_data_o, m[1] | m[0]);
      check("single rd", single_read_ok_o, !m[1]);
      check("quad on", quad_active_o, m[1] | m[0]);
      check("dual rd", dual_read_ok_o, !m[1]);
      check("armed", pin_reset_armed_o, !(m[1] & m[0]));
    end
    quad_enable_i <= 1'b0;
    cs_n_pin_i <= 1'b1;
    i_host.send(OP_EXIT_WIDE, 24'h0, 32'h0, 3'h0);
    i_host.idle();
    $display("t_modes done");
  endtask
  task automatic t_addr();
    for (int v = 0; v < 2; v++) begin
      i_host.send(v ? OP_ENTER_LONG : OP_EXIT_LONG, 24'h0, 32'h0, 3'h0);
      i_host.idle();
      check("long", current_addr_len_o, v[0]);
    end
    for (int v = 0; v < 2; v++) begin
      nv_pwrup_len_i <= v[0];
      nv_pwrup_len_upd_i <= 1'b1;
      tick(1);
      nv_pwrup_len_upd_i <= 1'b0;
      tick(1);
      check("pwrup", powerup_addr_len_o, v[0]);
      check("follow", current_addr_len_o, v[0]);
    end
    $display("t_addr done");
  endtask
  task automatic t_burst();
    i_host.send(OP_BURST_LEN, 24'h0, 32'h0000002A, 3'h1);
    i_host.idle();
    check("wrap len", wrap_len_o, 8'h01);
    check("latency", read_latency_o, 8'h0A);
    tick(1);
    check("wrap on", wrap_active_o, 8'h01);
    array_read_i <= 1'b0;
    tick(2);
    check("reg rd", wrap_active_o, 8'h00);
    expect_rd("burst", OP_READ_THREE, 24'h0, 8'h2A);
    $display("t_burst done");
  endtask
  // pin reset off then on, then a software reset; both reload 87h
  task automatic t_resets();
    i_host.wr(OP_WRITE_ANY, ADDR_CFG_TWO_V, 32'h60, 3'h0);
    io3_pin_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      check("pin ignored", hw_reset_o, 8'h00);
    end
    io3_pin_i <= 1'b1;
    tick(4);
    i_host.wr(OP_WRITE_ANY, ADDR_CFG_TWO_V, 32'h80, 3'h0);
    io3_pin_i <= 1'b0;
    for (int i = 0; i < 10 && hw_reset_o !== 1'b1; i++) begin
      tick(1);
    end
    check("pin reset", hw_reset_o, 8'h01);
    if (hw_reset_o !== 1'b1) begin
      close_out();
    end
    io3_pin_i <= 1'b1;
    tick(8);
    expect_rd("pin reload", OP_READ_TWO, 24'h0, 8'h87);
    i_host.wr(OP_WRITE_ANY, ADDR_CFG_TWO_V, 32'h60, 3'h0);
    sw_reset_i <= 1'b1;
    tick(1);
    sw_reset_i <= 1'b0;
    tick(1);
    expect_rd("sw two", OP_READ_TWO, 24'h0, 8'h87);
    expect_rd("sw three", OP_READ_THREE, 24'h0, 8'h75);
    $display("t_resets done");
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    n_fail = 0;
    checks_done = 0;
    clock_i = 1'b0;
    nrst_i = 1'b0;
    nv_config_two_i = 8'h96;
    nv_config_three_i = 8'hF5;
    nv_pwrup_len_upd_i = 1'b0;
    nv_pwrup_len_i = 1'b0;
    sw_reset_i = 1'b0;
    quad_enable_i = 1'b0;
    array_read_i = 1'b1;
    cs_n_pin_i = 1'b1;
    io3_pin_i = 1'b1;
    tick(6);
    nrst_i <= 1'b1;
    tick(1);
    t_reload();
    t_write();
    t_modes();
    t_addr();
    t_burst();
    t_resets();
    close_out();
  end
endmodule
`default_nettype wire
